// >>> rtl/acr_pkg.sv
/*
 * constants for the converter output configuration register bank:
 * register addresses, field positions, reset values and codes.
 * assumes a serial control port front end that delivers decoded
 * byte writes and reads with a 10-bit address.
 */
package acr_pkg;

   // ***********************************************************
   // widths
   // ***********************************************************
   localparam int ACR_AW = 10;
   localparam int ACR_DW = 8;

   // ***********************************************************
   // register addresses
   // ***********************************************************
   localparam logic [9:0] ACR_ADDR_INDEX = 10'h005;
   localparam logic [9:0] ACR_ADDR_PWR = 10'h008;
   localparam logic [9:0] ACR_ADDR_DIV = 10'h00b;
   localparam logic [9:0] ACR_ADDR_ENH = 10'h00c;
   localparam logic [9:0] ACR_ADDR_OMODE = 10'h014;
   localparam logic [9:0] ACR_ADDR_OADJ = 10'h015;
   localparam logic [9:0] ACR_ADDR_PHASE = 10'h016;
   localparam logic [9:0] ACR_ADDR_XFER = 10'h0ff;
   localparam logic [9:0] ACR_ADDR_OVR = 10'h100;

   // ***********************************************************
   // reset values
   // ***********************************************************
   localparam logic [7:0] ACR_RST_INDEX = 8'h03;
   localparam logic [7:0] ACR_RST_PWR = 8'h00;
   localparam logic [7:0] ACR_RST_ENH = 8'h00;
   localparam logic [7:0] ACR_RST_OMODE = 8'h01;
   localparam logic [7:0] ACR_RST_OADJ = 8'h00;
   localparam logic [7:0] ACR_RST_PHASE = 8'h03;
   localparam logic [7:0] ACR_RST_OVR = 8'h00;

   // ***********************************************************
   // writable bit masks (open bits read zero)
   // ***********************************************************
   localparam logic [7:0] ACR_MSK_INDEX = 8'h33;
   localparam logic [7:0] ACR_MSK_PWR = 8'h03;
   localparam logic [7:0] ACR_MSK_ENH = 8'h04;
   localparam logic [7:0] ACR_MSK_OMODE = 8'h45;
   localparam logic [7:0] ACR_MSK_OADJ = 8'h31;
   localparam logic [7:0] ACR_MSK_PHASE = 8'h7f;
   localparam logic [7:0] ACR_MSK_OVR = 8'h77;

   // ***********************************************************
   // field positions
   // ***********************************************************
   localparam int ACR_XFER_BIT = 0;
   localparam int ACR_CHOP_BIT = 2;
   localparam int ACR_IEEE_BIT = 6;
   localparam int ACR_INV_BIT = 2;
   localparam int ACR_TWOS_BIT = 0;
   localparam int ACR_DRV2X_BIT = 0;
   localparam int ACR_TERM_LSB = 4;
   localparam int ACR_IPH_LSB = 4;
   localparam int ACR_DIV_LSB = 0;
   localparam int ACR_DCOPH_LSB = 0;
   localparam int ACR_IDX_CLK_LSB = 4;
   localparam int ACR_IDX_CH_LSB = 0;
   localparam logic [1:0] ACR_TERM_NONE = 2'h0;

   // ***********************************************************
   // output clock phase range
   // ***********************************************************
   localparam logic [3:0] ACR_DCOPH_MAX = 4'hb;
   localparam int ACR_DEG_PER_STEP = 60;

   // power mode field codes
   typedef enum logic [1:0] {
      ACR_PM_NORMAL = 2'b00,
      ACR_PM_POWERDOWN = 2'b01,
      ACR_PM_STANDBY = 2'b10,
      ACR_PM_DIGRESET = 2'b11
   } acr_pmode_t;

endpackage : acr_pkg

// >>> rtl/acr_pwr_decode.sv
/*
 * power mode decoder: turns the two-bit mode field into datapath
 * clock enable, datapath reset and output enable, all registered.
 * assumes the mode field comes from a register in the same domain.
 */
`timescale 1ns/10ps
module acr_pwr_decode
   import acr_pkg::*;
(
   input wire logic ref_clk_i,
   input wire logic rstn_i,
   input wire logic [1:0] mode_i,
   output logic dp_clk_en_o,
   output logic dp_rst_o,
   output logic out_en_o,
   output logic [1:0] state_o
);

   acr_pmode_t mode;
   logic clk_en_next;
   logic rst_next;
   logic oen_next;

   // ***********************************************************
   // mode decode
   // ***********************************************************
   assign mode = acr_pmode_t'(mode_i);

   // the control port is never gated here, only the datapath
   always_comb begin
      clk_en_next = 1'b1;
      rst_next = 1'b0;
      oen_next = 1'b1;
      unique case (mode)
         ACR_PM_NORMAL: begin
            clk_en_next = 1'b1;
         end
         ACR_PM_POWERDOWN: begin
            clk_en_next = 1'b0;
            rst_next = 1'b1;
            oen_next = 1'b0;
         end
         ACR_PM_STANDBY: begin
            clk_en_next = 1'b0;
            oen_next = 1'b0;
         end
         ACR_PM_DIGRESET: begin
            rst_next = 1'b1;
            oen_next = 1'b0;
         end
      endcase
   end

   // registered so that the top outputs come from flops
   always_ff @(posedge ref_clk_i) begin
      if (!rstn_i) begin
         dp_clk_en_o <= 1'b1;
         dp_rst_o <= 1'b0;
         out_en_o <= 1'b1;
         state_o <= ACR_PM_NORMAL;
      end else begin
         dp_clk_en_o <= clk_en_next;
         dp_rst_o <= rst_next;
         out_en_o <= oen_next;
         state_o <= mode_i;
      end
   end

endmodule : acr_pwr_decode

// >>> rtl/acr_config_regs.sv
/*
 * output configuration register bank of a dual-channel converter,
 * written and read through the serial control port front end.
 * assumes the front end presents one-cycle write and read strobes
 * with address and byte, synchronous to ref_clk_i, and that only
 * a power-on reset drives rstn_i.
 */
// Operation
// - all registers except override act immediately on write
// - writing one to transfer bit zero applies pending override
// - power mode 00: both channels fully active
// - mode 01: stop datapath clocks, hold datapath reset, outputs off
// - mode 10 standby: clocks and outputs off, no datapath reset
// - mode 11: hold datapath reset, clocks keep running, outputs off, control port spared
// - control port works in every power mode; only power-on resets it
// - enhancement bit two enables first stage chopping
// - output mode bit six selects reduced-range signalling, else ansi
// - driver current follows signalling standard automatically
// - output mode bit two inverts every serial output bit
// - output mode bit zero defaults one: twos complement, else offset
// - output adjust bits five to four select termination resistor
// - output adjust bit zero doubles drive on clock outputs only
// - termination selection overrides double drive on clock outputs
// - input phase field delays sampling when divider active
// - data clock phase field shifts 60 degrees per step, 0 to 660
// - device index picks channel or clock outputs for writes
// - override writes stay inactive until transfer strobe
`timescale 1ns/10ps
module acr_config_regs
   import acr_pkg::*;
#(
   parameter int NUM_CH = 2
)(
   input wire logic ref_clk_i,
   input wire logic rstn_i,
   input wire logic wr_i,
   input wire logic rd_i,
   input wire logic [ACR_AW-1:0] addr_i,
   input wire logic [ACR_DW-1:0] wdata_i,
   output logic [ACR_DW-1:0] rdata_o,
   output logic rvalid_o,
   output logic [NUM_CH-1:0] chop_en_o,
   output logic [NUM_CH-1:0] lvds_ieee_o,
   output logic [NUM_CH-1:0] drv_cur_low_o,
   output logic [NUM_CH-1:0] out_invert_o,
   output logic [NUM_CH-1:0] twos_comp_o,
   output logic [NUM_CH-1:0] [1:0] term_sel_o,
   output logic clk_drv_2x_o,
   output logic [1:0] clk_term_sel_o,
   output logic [2:0] in_phase_o,
   output logic [3:0] dco_phase_o,
   output logic [7:0] ovr_active_o,
   output logic dp_clk_en_o,
   output logic dp_rst_o,
   output logic out_en_o,
   output logic [1:0] pmode_o
);

   // ***********************************************************
   // storage
   // ***********************************************************
   // per-channel copies; index bits choose which ones a write hits
   logic [7:0] idx_reg;
   logic [7:0] pwr_reg;
   logic [7:0] div_reg;
   logic [7:0] enh_reg [NUM_CH];
   logic [7:0] omode_reg [NUM_CH];
   logic [7:0] oadj_reg [NUM_CH];
   logic [7:0] clk_oadj_reg;
   logic [7:0] phase_reg;
   logic [7:0] ovr_pend_reg;
   logic [7:0] ovr_act_reg;
   logic [7:0] rdata_reg;
   logic rvalid_reg;
   logic [NUM_CH-1:0] chop_reg;
   logic [NUM_CH-1:0] ieee_reg;
   logic [NUM_CH-1:0] inv_reg;
   logic [NUM_CH-1:0] twos_reg;
   logic [NUM_CH-1:0] [1:0] term_reg;
   logic clk2x_reg;
   logic [1:0] clkterm_reg;
   logic [2:0] iph_reg;
   logic [3:0] dcoph_reg;

   // ***********************************************************
   // address decode
   // ***********************************************************
   function automatic logic hit(input logic [9:0] a, input logic [9:0] r);
      hit = (a == r);
   endfunction : hit

   wire we_index = wr_i && hit(addr_i, ACR_ADDR_INDEX);
   wire we_pwr = wr_i && hit(addr_i, ACR_ADDR_PWR);
   wire we_div = wr_i && hit(addr_i, ACR_ADDR_DIV);
   wire we_enh = wr_i && hit(addr_i, ACR_ADDR_ENH);
   wire we_omode = wr_i && hit(addr_i, ACR_ADDR_OMODE);
   wire we_oadj = wr_i && hit(addr_i, ACR_ADDR_OADJ);
   wire we_phase = wr_i && hit(addr_i, ACR_ADDR_PHASE);
   wire we_ovr = wr_i && hit(addr_i, ACR_ADDR_OVR);
   // only a written one commits; a written zero is a no-op
   wire xfer_go = wr_i && hit(addr_i, ACR_ADDR_XFER)
                  && wdata_i[ACR_XFER_BIT];
   wire [1:0] idx_ch = idx_reg[ACR_IDX_CH_LSB +: 2];
   wire [1:0] idx_clk = idx_reg[ACR_IDX_CLK_LSB +: 2];
   wire clk_sel = |idx_clk;

   // reads see the first selected channel
   wire sel_rd = ~idx_ch[0] & idx_ch[1];

   // ***********************************************************
   // read mux
   // ***********************************************************
   logic [7:0] rd_mux;
   always_comb begin
      rd_mux = 8'h00;
      unique case (1'b1)
         hit(addr_i, ACR_ADDR_INDEX): rd_mux = idx_reg;
         hit(addr_i, ACR_ADDR_PWR): rd_mux = pwr_reg;
         hit(addr_i, ACR_ADDR_DIV): rd_mux = div_reg;
         hit(addr_i, ACR_ADDR_ENH): rd_mux = enh_reg[sel_rd];
         hit(addr_i, ACR_ADDR_OMODE): rd_mux = omode_reg[sel_rd];
         hit(addr_i, ACR_ADDR_OADJ): begin
            rd_mux = clk_sel ? clk_oadj_reg : oadj_reg[sel_rd];
         end
         hit(addr_i, ACR_ADDR_PHASE): rd_mux = phase_reg;
         hit(addr_i, ACR_ADDR_OVR): rd_mux = ovr_pend_reg;
         default: rd_mux = 8'h00; // transfer and unmapped read zero
      endcase
   end

   // ***********************************************************
   // global registers
   // ***********************************************************
   // rstn_i is power-on only, so no power mode resets these
   always_ff @(posedge ref_clk_i) begin
      if (!rstn_i) begin
         idx_reg <= ACR_RST_INDEX;
         pwr_reg <= ACR_RST_PWR;
         div_reg <= 8'h00;
         phase_reg <= ACR_RST_PHASE;
         ovr_pend_reg <= ACR_RST_OVR;
         ovr_act_reg <= ACR_RST_OVR;
         clk_oadj_reg <= ACR_RST_OADJ;
      end else begin
         if (we_index) idx_reg <= wdata_i & ACR_MSK_INDEX;
         if (we_pwr) pwr_reg <= wdata_i & ACR_MSK_PWR;
         if (we_div) div_reg <= wdata_i;
         if (we_phase) phase_reg <= wdata_i & ACR_MSK_PHASE;
         if (we_ovr) ovr_pend_reg <= wdata_i & ACR_MSK_OVR;
         if (xfer_go) ovr_act_reg <= ovr_pend_reg;
         if (we_oadj && clk_sel) begin
            clk_oadj_reg <= wdata_i & ACR_MSK_OADJ;
         end
      end
   end

   // per-channel registers, gated by the index channel bits
   always_ff @(posedge ref_clk_i) begin
      if (!rstn_i) begin
         for (int i = 0; i < NUM_CH; i++) begin
            enh_reg[i] <= ACR_RST_ENH;
            omode_reg[i] <= ACR_RST_OMODE;
            oadj_reg[i] <= ACR_RST_OADJ;
         end
      end else begin
         for (int i = 0; i < NUM_CH; i++) begin
            if (idx_ch[i]) begin
               if (we_enh) enh_reg[i] <= wdata_i & ACR_MSK_ENH;
               if (we_omode) omode_reg[i] <= wdata_i & ACR_MSK_OMODE;
               if (we_oadj) oadj_reg[i] <= wdata_i & ACR_MSK_OADJ;
            end
         end
      end
   end

   // ***********************************************************
   // field extraction to datapath
   // ***********************************************************
   // divider ratio zero means no division, so phase has no effect
   wire div_on = |div_reg[ACR_DIV_LSB +: 3];
   wire [2:0] iph_next = div_on ? phase_reg[ACR_IPH_LSB +: 3]
                                : 3'h0;
   // out-of-range codes are clamped rather than wrapping
   wire [3:0] dcoph_raw = phase_reg[ACR_DCOPH_LSB +: 4];
   wire [3:0] dcoph_next = (dcoph_raw > ACR_DCOPH_MAX) ? ACR_DCOPH_MAX
                                                      : dcoph_raw;
   wire [1:0] cterm = clk_oadj_reg[ACR_TERM_LSB +: 2];
   wire c2x_next = clk_oadj_reg[ACR_DRV2X_BIT]
                   && (cterm == ACR_TERM_NONE);

   always_ff @(posedge ref_clk_i) begin
      if (!rstn_i) begin
         chop_reg <= '0;
         ieee_reg <= '0;
         inv_reg <= '0;
         twos_reg <= '1;
         term_reg <= '0;
         clk2x_reg <= 1'b0;
         clkterm_reg <= ACR_TERM_NONE;
         iph_reg <= 3'h0;
         dcoph_reg <= ACR_RST_PHASE[3:0];
      end else begin
         for (int i = 0; i < NUM_CH; i++) begin
            chop_reg[i] <= enh_reg[i][ACR_CHOP_BIT];
            ieee_reg[i] <= omode_reg[i][ACR_IEEE_BIT];
            inv_reg[i] <= omode_reg[i][ACR_INV_BIT];
            twos_reg[i] <= omode_reg[i][ACR_TWOS_BIT];
            term_reg[i] <= oadj_reg[i][ACR_TERM_LSB +: 2];
         end
         clk2x_reg <= c2x_next;
         clkterm_reg <= cterm;
         iph_reg <= iph_next;
         dcoph_reg <= dcoph_next;
      end
   end

   // read answer one cycle after the strobe
   always_ff @(posedge ref_clk_i) begin
      if (!rstn_i) begin
         rdata_reg <= 8'h00;
         rvalid_reg <= 1'b0;
      end else begin
         rdata_reg <= rd_i ? rd_mux : rdata_reg;
         rvalid_reg <= rd_i;
      end
   end

   // ***********************************************************
   // power mode decode
   // ***********************************************************
   acr_pwr_decode u_pwr (
      .ref_clk_i(ref_clk_i),
      .rstn_i(rstn_i),
      .mode_i(pwr_reg[1:0]),
      .dp_clk_en_o(dp_clk_en_o),
      .dp_rst_o(dp_rst_o),
      .out_en_o(out_en_o),
      .state_o(pmode_o)
   );

   // ***********************************************************
   // outputs
   // ***********************************************************
   assign rdata_o = rdata_reg;
   assign rvalid_o = rvalid_reg;
   assign chop_en_o = chop_reg;
   assign lvds_ieee_o = ieee_reg;
   assign drv_cur_low_o = ieee_reg;
   assign out_invert_o = inv_reg;
   assign twos_comp_o = twos_reg;
   assign term_sel_o = term_reg;
   assign clk_drv_2x_o = clk2x_reg;
   assign clk_term_sel_o = clkterm_reg;
   assign in_phase_o = iph_reg;
   assign dco_phase_o = dcoph_reg;
   assign ovr_active_o = ovr_act_reg;

endmodule : acr_config_regs

// >>> verif/acr_config_regs_properties.sv
/* port checker for the config register bank.
   assumes it is bound onto acr_config_regs, one clock domain. */
`timescale 1ns/10ps
module acr_chk
   import acr_pkg::*;
#(
   parameter int NUM_CH = 2
)(
   input wire logic ref_clk_i,
   input wire logic rstn_i,
   input wire logic wr_i,
   input wire logic rd_i,
   input wire logic [ACR_AW-1:0] addr_i,
   input wire logic [ACR_DW-1:0] wdata_i,
   input wire logic rvalid_o,
   input wire logic [NUM_CH-1:0] lvds_ieee_o,
   input wire logic [NUM_CH-1:0] drv_cur_low_o,
   input wire logic clk_drv_2x_o,
   input wire logic [1:0] clk_term_sel_o,
   input wire logic [3:0] dco_phase_o,
   input wire logic [7:0] ovr_active_o,
   input wire logic dp_clk_en_o,
   input wire logic dp_rst_o,
   input wire logic out_en_o
);
   default clocking cb @(posedge ref_clk_i); endclocking
   default disable iff (!rstn_i);
   // ******************************************************
   // write decodes and relations
   // ******************************************************
   wire logic pw_wr = wr_i && (addr_i == ACR_ADDR_PWR);
   wire logic xf_wr = wr_i && (addr_i == ACR_ADDR_XFER) && wdata_i[0];
   read_answer_a: assert property (rd_i |=> rvalid_o)
      else $error("read not answered");
   answer_alone_a: assert property (!rd_i |=> !rvalid_o)
      else $error("read answer without request");
   drive_follow_a: assert property (drv_cur_low_o == lvds_ieee_o)
      else $error("driver current not tied to standard");
   pm_normal_a: assert property (pw_wr && wdata_i[1:0] == 2'b00 |->
      ##2 (dp_clk_en_o && out_en_o && !dp_rst_o))
      else $error("normal mode outputs wrong");
   pm_down_a: assert property (pw_wr && wdata_i[1:0] == 2'b01 |->
      ##2 (!dp_clk_en_o && !out_en_o && dp_rst_o))
      else $error("power down outputs wrong");
   pm_standby_a: assert property (pw_wr && wdata_i[1:0] == 2'b10 |->
      ##2 (!dp_clk_en_o && !out_en_o && !dp_rst_o))
      else $error("standby outputs wrong");
   pm_reset_a: assert property (pw_wr && wdata_i[1:0] == 2'b11 |->
      ##2 dp_rst_o)
      else $error("digital reset not applied");
   term_wins_a: assert property (clk_term_sel_o != 2'h0 |-> !clk_drv_2x_o)
      else $error("double drive beside termination");
   phase_range_a: assert property (dco_phase_o <= ACR_DCOPH_MAX)
      else $error("clock phase code out of range");
   ovr_hold_a: assert property (!xf_wr |=> $stable(ovr_active_o))
      else $error("override changed without transfer");
endmodule : acr_chk

bind acr_config_regs acr_chk #(.NUM_CH(NUM_CH)) chk_u (
   .ref_clk_i(ref_clk_i), .rstn_i(rstn_i), .wr_i(wr_i), .rd_i(rd_i),
   .addr_i(addr_i), .wdata_i(wdata_i), .rvalid_o(rvalid_o),
   .lvds_ieee_o(lvds_ieee_o), .drv_cur_low_o(drv_cur_low_o),
   .clk_drv_2x_o(clk_drv_2x_o), .clk_term_sel_o(clk_term_sel_o),
   .dco_phase_o(dco_phase_o), .ovr_active_o(ovr_active_o),
   .dp_clk_en_o(dp_clk_en_o), .dp_rst_o(dp_rst_o), .out_en_o(out_en_o));

// >>> verif/acr_host_model.sv
/* control port host: byte writes and reads as one-cycle strobes.
   assumes the bench calls its tasks; drives at the falling edge. */
`timescale 1ns/10ps
module acr_host_model
   import acr_pkg::*;
(
   input wire logic ref_clk_i,
   input wire logic rvalid_i,
   input wire logic [7:0] rdata_i,
   output logic wr_o,
   output logic rd_o,
   output logic [ACR_AW-1:0] addr_o,
   output logic [ACR_DW-1:0] wdata_o
);
   logic [2:0] div_ratio = 3'h0;
   initial begin
      wr_o = 1'b0;
      rd_o = 1'b0;
      addr_o = 10'h000;
      wdata_o = 8'h00;
   end
   // ******************************************************
   // bus cycles
   // ******************************************************
   // idle lines flip so a stale byte never looks fresh
   task automatic write(input logic [9:0] a, input logic [7:0] d,
                        output logic [7:0] sent);
      sent = d;
      if (a == ACR_ADDR_DIV) div_ratio = d[2:0];
      // phase above the ratio is never sent
      if (a == ACR_ADDR_PHASE && d[6:4] > div_ratio) sent[6:4] = div_ratio;
      @(negedge ref_clk_i);
      wr_o = 1'b1;
      addr_o = a;
      wdata_o = sent;
      @(negedge ref_clk_i);
      wr_o = 1'b0;
      addr_o = ~addr_o;
      wdata_o = ~wdata_o;
   endtask : write
   task automatic read(input logic [9:0] a, output logic [8:0] got);
      @(negedge ref_clk_i);
      rd_o = 1'b1;
      addr_o = a;
      @(negedge ref_clk_i);
      got = {rvalid_i, rdata_i};
      rd_o = 1'b0;
      addr_o = ~addr_o;
   endtask : read
endmodule : acr_host_model

// >>> verif/acr_config_regs_tb_top.sv
/* self-checking bench for the config register bank with a shadow
   model. assumes the host model and the bound port checker. */
`timescale 1ns/10ps
module acr_config_regs_tb_top
   import acr_pkg::*;
;
   logic ref_clk_i = 1'b0;
   logic rstn_i = 1'b0;
   logic wr, rd, clk2x, dpclk, dprst, outen, rvalid;
   logic [9:0] addr;
   logic [7:0] wdata, rdata, ovr;
   logic [1:0] chop, ieee, drvlow, inv, twos, clkterm, pmode;
   logic [1:0][1:0] term;
   logic [2:0] inph;
   logic [3:0] data_bit_clock_out;
   logic [7:0] m_idx, m_pwr, m_div, m_ph, m_clk, m_ovr, m_pend, s;
   logic [7:0] m_enh [2], m_om [2], m_oa [2];
   logic [8:0] g;
   logic [9:0] a;
   logic [9:0] tab [8] = '{ACR_ADDR_INDEX, ACR_ADDR_PWR, ACR_ADDR_ENH,
      ACR_ADDR_OMODE, ACR_ADDR_OADJ, ACR_ADDR_PHASE, ACR_ADDR_XFER, 10'h03a};
   logic [7:0] idx_tab [4] = '{8'h01, 8'h02, 8'h03, 8'h30};
   int seed = 32'h764dfcb2;
   int bad_count = 0, comparisons = 0, cycles = 0;
   always #20 ref_clk_i = ~ref_clk_i;
   acr_host_model host_u (.ref_clk_i(ref_clk_i), .rvalid_i(rvalid),
      .rdata_i(rdata), .wr_o(wr), .rd_o(rd), .addr_o(addr), .wdata_o(wdata));
   acr_config_regs #(.NUM_CH(2)) dut_u (.ref_clk_i(ref_clk_i),
      .rstn_i(rstn_i), .wr_i(wr), .rd_i(rd), .addr_i(addr), .wdata_i(wdata),
      .rdata_o(rdata), .rvalid_o(rvalid), .chop_en_o(chop),
      .lvds_ieee_o(ieee), .drv_cur_low_o(drvlow), .out_invert_o(inv),
      .twos_comp_o(twos), .term_sel_o(term), .clk_drv_2x_o(clk2x),
      .clk_term_sel_o(clkterm), .in_phase_o(inph), .dco_phase_o(data_bit_clock_out),
      .ovr_active_o(ovr), .dp_clk_en_o(dpclk), .dp_rst_o(dprst),
      .out_en_o(outen), .pmode_o(pmode));
   // ******************************************************
   // shadow model and compares
   // ******************************************************
   task automatic mdl_wr(input logic [9:0] wa, input logic [7:0] d);
      logic clk_sel;
      clk_sel = (m_idx[5:4] != 2'h0);
      case (wa)
         ACR_ADDR_INDEX: m_idx = d & ACR_MSK_INDEX;
         ACR_ADDR_PWR: m_pwr = d & ACR_MSK_PWR;
         ACR_ADDR_DIV: m_div = d;
         ACR_ADDR_PHASE: m_ph = d & ACR_MSK_PHASE;
         ACR_ADDR_OVR: m_pend = d & ACR_MSK_OVR;
         ACR_ADDR_XFER: if (d[0]) m_ovr = m_pend;
         ACR_ADDR_OADJ: if (clk_sel) m_clk = d & ACR_MSK_OADJ;
         default: ;
      endcase
      for (int c = 0; c < 2; c++) begin
         if (m_idx[c] && wa == ACR_ADDR_ENH) m_enh[c] = d & ACR_MSK_ENH;
         if (m_idx[c] && wa == ACR_ADDR_OMODE) m_om[c] = d & ACR_MSK_OMODE;
         // channel copies follow their index bits even with clocks picked
         if (m_idx[c] && wa == ACR_ADDR_OADJ) m_oa[c] = d & ACR_MSK_OADJ;
      end
   endtask : mdl_wr
   function automatic logic [7:0] mdl_rd(input logic [9:0] ra);
      int c;
      c = (m_idx[1:0] == 2'b10) ? 1 : 0;
      case (ra)
         ACR_ADDR_INDEX: return m_idx;
         ACR_ADDR_PWR: return m_pwr;
         ACR_ADDR_DIV: return m_div;
         ACR_ADDR_OVR: return m_pend;
         ACR_ADDR_ENH: return m_enh[c];
         ACR_ADDR_OMODE: return m_om[c];
         ACR_ADDR_OADJ: return (m_idx[5:4] != 2'h0) ? m_clk : m_oa[c];
         ACR_ADDR_PHASE: return m_ph;
         default: return 8'h00;
      endcase
   endfunction : mdl_rd
   task automatic chk_rd(input logic [8:0] got, input logic [8:0] exp);
      comparisons++;
      if (got !== exp) begin
         bad_count++;
         $display("BAD %0t read got %h exp %h", $time, got, exp);
      end
   endtask : chk_rd
   task automatic chk_out(input logic [36:0] got, input logic [36:0] exp);
      comparisons++;
      if (got !== exp) begin
         bad_count++;
         $display("BAD %0t outputs got %h exp %h", $time, got, exp);
      end
   endtask : chk_out
   // every output but rdata and rvalid as one word; every mode but 00 must drop output enable
   task automatic chk_outs();
      logic [1:0] pm;
      logic [3:0] dc;
      pm = m_pwr[1:0];
      dc = (m_ph[3:0] > ACR_DCOPH_MAX) ? ACR_DCOPH_MAX : m_ph[3:0];
      chk_out({chop, ieee, drvlow, inv, twos, term, clk2x, clkterm, inph,
         data_bit_clock_out, ovr, dpclk, dprst, outen, pmode},
         {m_enh[1][2], m_enh[0][2], m_om[1][6], m_om[0][6], m_om[1][6],
         m_om[0][6], m_om[1][2], m_om[0][2], m_om[1][0], m_om[0][0],
         m_oa[1][5:4], m_oa[0][5:4], m_clk[0] && (m_clk[5:4] == 2'h0),
         m_clk[5:4], (m_div[2:0] == 3'h0) ? 3'h0 : m_ph[6:4], dc, m_ovr,
         !(pm[0] ^ pm[1]), pm[0], pm == 2'b00, pm});
   endtask : chk_outs
   task automatic do_write(input logic [9:0] wa, input logic [7:0] d);
      host_u.write(wa, d, s);
      mdl_wr(wa, s);
      @(negedge ref_clk_i);
      chk_outs();
   endtask : do_write
   task automatic do_read(input logic [9:0] ra);
      host_u.read(ra, g);
      chk_rd(g, {1'b1, mdl_rd(ra)});
   endtask : do_read
   task automatic conclude();
      $display("comparisons %0d bad_count %0d", comparisons, bad_count);
      if (bad_count == 0 && comparisons > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask : conclude
   // ******************************************************
   // run
   // ******************************************************
   // bounded run: a hang counts against the design
   always @(posedge ref_clk_i) begin
      cycles++;
      if (cycles == 6000) begin
         bad_count++;
         conclude();
      end
   end
   initial begin
      {m_idx, m_pwr, m_div, m_ph} = {ACR_RST_INDEX, ACR_RST_PWR, 8'h00,
         ACR_RST_PHASE};
      {m_clk, m_ovr, m_pend} = {ACR_RST_OADJ, ACR_RST_OVR, ACR_RST_OVR};
      m_enh = '{ACR_RST_ENH, ACR_RST_ENH};
      m_om = '{ACR_RST_OMODE, ACR_RST_OMODE};
      m_oa = '{ACR_RST_OADJ, ACR_RST_OADJ};
      repeat (8) @(negedge ref_clk_i);
      rstn_i = 1'b1;
      chk_outs();
      foreach (tab[i]) do_read(tab[i]);
      do_write(ACR_ADDR_DIV, 8'h01 | 8'($random(seed)));
      do_read(ACR_ADDR_DIV);
      for (int i = 0; i < 4; i++) begin
         do_write(ACR_ADDR_PWR, 8'(i) | 8'hf0);
         do_read(ACR_ADDR_OMODE);
      end
      do_write(ACR_ADDR_INDEX, 8'h30);
      foreach (idx_tab[i]) begin
         do_write(ACR_ADDR_OADJ, {idx_tab[i][3:0], 4'h1});
      end
      do_read(ACR_ADDR_OADJ);
      // channels and clocks picked together: both copies take the write
      do_write(ACR_ADDR_INDEX, ACR_RST_INDEX | 8'h30);
      do_write(ACR_ADDR_OADJ, 8'h20);
      do_read(ACR_ADDR_OADJ);
      for (int i = 0; i < 3; i++) begin
         do_write(ACR_ADDR_OVR, 8'($random(seed)));
         do_read(ACR_ADDR_OVR);
         do_write(ACR_ADDR_XFER, 8'h00);
         do_write(ACR_ADDR_XFER, 8'h01);
         do_read(ACR_ADDR_XFER);
      end
      for (int i = 0; i < 80; i++) begin
         a = tab[$unsigned($random(seed)) % 8];
         s = 8'($random(seed));
         if (a == ACR_ADDR_INDEX) s = idx_tab[s[1:0]] | (s & 8'hcc);
         do_write(a, s);
         do_read(a);
      end
      // dropping the divider must silence the stored input phase
      do_write(ACR_ADDR_DIV, 8'h00);
      conclude();
   end
endmodule : acr_config_regs_tb_top
